// File: pkg/bdsr_defs.vh
`ifndef BDSR_DEFS_VH
`define BDSR_DEFS_VH
`define BDSR_OFS_REF_PWR      32'h00002050
`define BDSR_OFS_CODE         32'h00002120
`define BDSR_OFS_SW           32'h00002124
`define BDSR_OFS_CFG          32'h00002128
`define BDSR_OFS_CM           32'h0000235c
`define BDSR_CFG_RESET        7'h02
`define BDSR_CFG_WAVE_BIT     6
`define BDSR_CFG_DIAG_BIT     5
`define BDSR_CFG_PWD_BIT      1
`define BDSR_CFG_WEN_BIT      0
`define BDSR_SW_OVR_BIT       5
`define BDSR_CODE6_HI         17
`define BDSR_CODE6_LO         12
`define BDSR_CODE12_HI        11
`define BDSR_CODE12_LO        0
`define BDSR_REF_BUF_BIT      1
`define BDSR_REF_BG_BIT       0
`define BDSR_CM_EN_BIT        3
`define BDSR_NORMAL_SW        5'h08
`define BDSR_DIAG_SW          5'h01
`endif

// File: design/bdsr_apb_if.v
`timescale 1ns/1ps
`default_nettype none
// Zero-wait APB slave front end; strobes are one-cycle pulses.
module bdsr_apb_if (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   output wire        wr_stb,
   output wire        rd_stb
);
   assign wr_stb = psel & penable & pwrite;
   assign rd_stb = psel & penable & ~pwrite;
endmodule
`default_nettype wire

// File: design/bdsr_sw_route.v
`timescale 1ns/1ps
`include "bdsr_defs.vh"
`default_nettype none
module bdsr_sw_route (
   input  wire [4:0]  sw_bits,
   input  wire        override,
   input  wire        diag,
   input  wire        pwd,
   output reg  [4:0]  sw_out
);
   always @* begin
      if (override) begin
         sw_out = sw_bits;
      end else if (diag) begin
         sw_out = `BDSR_DIAG_SW;
      end else begin
         sw_out = `BDSR_NORMAL_SW;
      end
      if (pwd) begin
         sw_out = 5'h00;
      end
   end
endmodule
`default_nettype wire

// File: design/bdsr_regs.v
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "bdsr_defs.vh"
`default_nettype none
module bdsr_regs #(
   parameter [1:0] SW32_RESET = 2'b00
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   output reg  [4:0]  dac_switch,
   output reg  [5:0]  code_six_bit,
   output reg  [11:0] code_twelve_bit,
   output reg         ref_buffer_power_down,
   output reg         bandgap_power_down,
   output reg         common_mode_switch_enable,
   output reg         dac_power_down
);
   reg  [6:0]  cfg_r;
   reg  [5:0]  sw_r;
   reg  [17:0] code_r;
   reg  [1:0]  ref_r;
   reg         cm_r;
   wire        wr_stb;
   wire        rd_stb;
   wire [4:0]  sw_nxt;
   reg  [31:0] rd_nxt;
   reg         hit;

   // Zero wait states keep the bus simple; pready is constant high.
   assign pready = 1'b1;

   bdsr_apb_if u_apb (
      .ref_clk (ref_clk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .wr_stb  (wr_stb),
      .rd_stb  (rd_stb)
   );

   always @* begin
      hit = 1'b1;
      rd_nxt = 32'h00000000;
      case (paddr)
         `BDSR_OFS_CFG:     rd_nxt = {25'h0000000, cfg_r};
         `BDSR_OFS_SW:      rd_nxt = {26'h0000000, sw_r};
         `BDSR_OFS_CODE:    rd_nxt = {14'h0000, code_r};
         `BDSR_OFS_REF_PWR: rd_nxt = {30'h00000000, ref_r};
         `BDSR_OFS_CM:      rd_nxt = {28'h0000000, cm_r, 3'h0};
         default:           hit = 1'b0;
      endcase
   end

   // Read data is combinational from the registers so the access phase
   // completes with the current value.
   always @* begin
      prdata = rd_stb ? rd_nxt : 32'h00000000;
      pslverr = (psel & penable) & ~hit;
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         cfg_r <= `BDSR_CFG_RESET;
         sw_r <= {2'b00, SW32_RESET, 2'b00};
         code_r <= 18'h00000;
         ref_r <= 2'b00;
         cm_r <= 1'b0;
      end else begin
         if (wr_stb && paddr == `BDSR_OFS_CFG) begin
            cfg_r <= pwdata[6:0];
         end
         if (wr_stb && paddr == `BDSR_OFS_SW) begin
            sw_r <= pwdata[5:0];
         end
         if (!cfg_r[`BDSR_CFG_WEN_BIT]) begin
            code_r <= 18'h00000;
         end else if (wr_stb && paddr == `BDSR_OFS_CODE) begin
            code_r <= pwdata[17:0];
         end
         if (wr_stb && paddr == `BDSR_OFS_REF_PWR) begin
            ref_r <= pwdata[1:0];
         end
         if (wr_stb && paddr == `BDSR_OFS_CM) begin
            cm_r <= pwdata[`BDSR_CM_EN_BIT];
         end
      end
   end

   bdsr_sw_route u_route (
      .sw_bits  (sw_r[4:0]),
      .override (sw_r[`BDSR_SW_OVR_BIT]),
      .diag     (cfg_r[`BDSR_CFG_DIAG_BIT]),
      .pwd      (cfg_r[`BDSR_CFG_PWD_BIT]),
      .sw_out   (sw_nxt)
   );

   // Outputs are flopped once so the analog controls never glitch.
   always @(posedge ref_clk) begin
      if (rst) begin
         dac_switch <= 5'h00;
         code_six_bit <= 6'h00;
         code_twelve_bit <= 12'h000;
         ref_buffer_power_down <= 1'b0;
         bandgap_power_down <= 1'b0;
         common_mode_switch_enable <= 1'b0;
         dac_power_down <= 1'b1;
      end else begin
         dac_switch <= sw_nxt;
         code_six_bit <= code_r[`BDSR_CODE6_HI:`BDSR_CODE6_LO];
         code_twelve_bit <= code_r[`BDSR_CODE12_HI:`BDSR_CODE12_LO];
         ref_buffer_power_down <= ref_r[`BDSR_REF_BUF_BIT];
         bandgap_power_down <= ref_r[`BDSR_REF_BG_BIT];
         common_mode_switch_enable <= cm_r;
         dac_power_down <= cfg_r[`BDSR_CFG_PWD_BIT];
      end
   end
endmodule
`default_nettype wire

// File: verification/bdsr_chk.sv
`timescale 1ns/1ps
`include "bdsr_defs.vh"
`default_nettype none
module bdsr_chk (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [4:0]  dac_switch,
   input wire logic [5:0]  code_six_bit,
   input wire logic [11:0] code_twelve_bit,
   input wire logic        ref_buffer_power_down,
   input wire logic        bandgap_power_down,
   input wire logic        common_mode_switch_enable,
   input wire logic        dac_power_down
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire acc = psel && penable;
   wire wr  = acc && pwrite;
   wire map = paddr inside {`BDSR_OFS_REF_PWR, `BDSR_OFS_CODE,
      `BDSR_OFS_SW, `BDSR_OFS_CFG, `BDSR_OFS_CM};
   AST_RST: assert property ($fell(rst)
      |-> dac_power_down && dac_switch == 5'h00) else $error("reset state");
   AST_PWD: assert property (dac_power_down && $past(dac_power_down)
      |-> dac_switch == 5'h00) else $error("switch closed in power-down");
   AST_ERR: assert property (acc && !map |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_CM: assert property (wr && paddr == `BDSR_OFS_CM |-> ##2
      common_mode_switch_enable == $past(pwdata[3], 2)) else $error("cm");
   AST_REF: assert property (wr && paddr == `BDSR_OFS_REF_PWR |-> ##2
      {ref_buffer_power_down, bandgap_power_down} == $past(pwdata[1:0], 2))
      else $error("reference power-down wrong");
   AST_OVR: assert property (wr && pwdata[5]
      && paddr == `BDSR_OFS_SW && !dac_power_down ##1 !dac_power_down[*2]
      |-> dac_switch == $past(pwdata[4:0], 2)) else $error("override wrong");
   AST_WEN: assert property (wr && paddr == `BDSR_OFS_CFG && !pwdata[0]
      |-> ##3 code_six_bit == 6'h00 && code_twelve_bit == 12'h000)
      else $error("code not cleared");
   AST_RSV: assert property (acc && !pwrite && paddr == `BDSR_OFS_CODE
      |-> prdata[31:18] == 14'h0000) else $error("reserved code bits set");
endmodule
`default_nettype wire

// File: verification/bias_dac_switch_reference_regs_test.sv
`timescale 1ns/1ps
`include "bdsr_defs.vh"
`default_nettype none
module bias_dac_switch_reference_regs_test;
   logic        ref_clk = 1'h0, rst = 1'h1, psel = 1'h0;
   logic        penable = 1'h0, pwrite = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, d;
   logic        pready, pslverr, ref_buffer_power_down, bandgap_power_down;
   logic        common_mode_switch_enable, dac_power_down;
   logic [4:0]  dac_switch;
   logic [5:0]  code_six_bit;
   logic [11:0] code_twelve_bit;
   logic [32:0] q[$];
   logic [31:0] ad[4] = '{`BDSR_OFS_REF_PWR, `BDSR_OFS_CM, `BDSR_OFS_CODE,
      `BDSR_OFS_SW};
   logic [31:0] mk[4] = '{32'h3, 32'h8, 32'h3ffff, 32'h3f};
   integer      errors = 0, n_checks = 0, seed = 32'h7c340147;
   always #2 ref_clk = ~ref_clk;
   bdsr_regs u_dut (.*);
   task chk(input logic [32:0] s, input logic [32:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %0t saw %h want %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task bus(input logic w, input logic [31:0] a, dt, input logic [32:0] e);
      if (!w) q.push_back(e);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (!pready);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Outputs lag the register by a clock, so three edges are allowed.
   task outs(input logic [4:0] e);
      repeat (3) @(posedge ref_clk);
      chk({code_six_bit, code_twelve_bit, dac_switch}, {d[17:0], e});
   endtask
   always @(posedge ref_clk)
      if (psel && penable && pready && !pwrite)
         chk({pslverr, prdata}, q.pop_front());
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'h0;
      bus(1'h0, `BDSR_OFS_SW, 32'h0, 33'h0);
      bus(1'h0, `BDSR_OFS_CFG, 32'h0, 33'h2);
      chk(dac_power_down, 1'h1);
      bus(1'h1, `BDSR_OFS_CODE, 32'h3ffff, 33'h0);
      bus(1'h0, `BDSR_OFS_CODE, 32'h0, 33'h0);
      bus(1'h0, 32'h2200, 32'h0, 33'h100000000);
      $display("reset and refusal test done");
      bus(1'h1, `BDSR_OFS_CFG, 32'h1, 33'h0);
      repeat (3) begin
         d = $random(seed) | 32'h20;
         foreach (ad[k]) begin
            bus(1'h1, ad[k], d, 33'h0);
            bus(1'h0, ad[k], 32'h0, {1'h0, d & mk[k]});
         end
         outs(d[4:0]);
         chk({ref_buffer_power_down, bandgap_power_down,
            common_mode_switch_enable, dac_power_down},
            {d[1:0], d[3], 1'h0});
      end
      $display("register test done");
      bus(1'h1, `BDSR_OFS_SW, 32'h0, 33'h0);
      outs(5'h08);
      bus(1'h1, `BDSR_OFS_CFG, 32'h21, 33'h0);
      outs(5'h01);
      bus(1'h1, `BDSR_OFS_CFG, 32'h23, 33'h0);
      bus(1'h1, `BDSR_OFS_SW, 32'h3f, 33'h0);
      outs(5'h00);
      chk(dac_power_down, 1'h1);
      bus(1'h1, `BDSR_OFS_CFG, 32'h0, 33'h0);
      d = 32'h0;
      outs(5'h1f);
      $display("switch mode test done");
      conclude;
   end
   initial begin
      #20000;
      errors++;
      conclude;
   end
endmodule
bind bdsr_regs bdsr_chk u_chk (.*);
`default_nettype wire
